// ==== hw/qbpe_pkg.sv ====
/*
 * Shared constants and types of the quasi-bidirectional port expander.
 * Assumes a single 250 MHz clock domain; no bus of its own beyond the serial pins.
 */
package qbpe_pkg;

   localparam int          QBPE_PORT_W     = 8;
   localparam int          QBPE_SYNC_W     = 13;
   localparam logic [3:0]  QBPE_ADDR_FIXED = 4'h7;
   localparam logic [7:0]  QBPE_LATCH_RST  = 8'hFF;
   localparam logic [7:0]  QBPE_REF_RST    = 8'hFF;
   localparam logic [3:0]  QBPE_BITS_BYTE  = 4'h8;
   localparam logic [3:0]  QBPE_LAST_BIT   = 4'h7;
   localparam int          QBPE_SYNC_SCL   = 12;
   localparam int          QBPE_SYNC_SDA   = 11;
   localparam int          QBPE_SYNC_A2    = 10;
   localparam int          QBPE_SYNC_A1    = 9;
   localparam int          QBPE_SYNC_A0    = 8;

   typedef enum logic [7:0] {
      QBPE_IDLE     = 8'h01,
      QBPE_ADDR     = 8'h02,
      QBPE_ADDR_ACK = 8'h04,
      QBPE_WR_DATA  = 8'h08,
      QBPE_WR_ACK   = 8'h10,
      QBPE_RD_DATA  = 8'h20,
      QBPE_RD_ACK   = 8'h40,
      QBPE_IGNORE   = 8'h80
   } qbpe_state_e;

   typedef struct packed {
      logic start;
      logic stop;
      logic scl_rise;
      logic scl_fall;
      logic sda;
   } qbpe_bus_ev_s;

endpackage

// ==== hw/qbpe_sync.sv ====
/*
 * Three-stage synchroniser with agreement filter for asynchronous inputs.
 * Assumes inputs are stable for several clocks; output moves only when stages two and three agree.
 */
module qbpe_sync
   import qbpe_pkg::*;
#(
   parameter int              W   = 1,
   parameter logic [W-1:0]    RST = '1
) (
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire logic [W-1:0]  d,
   output logic      [W-1:0]  q
);

   logic [W-1:0]  s1_q;
   logic [W-1:0]  s2_q;
   logic [W-1:0]  s3_q;
   logic [W-1:0]  agree;
   logic [W-1:0]  q_d;

   assign agree = ~(s2_q ^ s3_q);
   assign q_d   = (agree & s3_q) | (~agree & q);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
         q    <= RST;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q    <= q_d;
      end
   end

endmodule

// ==== hw/qbpe_port.sv ====
/*
 * Output latch and pin drive of the 8-bit quasi-bidirectional port.
 * Assumes load and scl_fall are single-cycle pulses from the serial engine.
 */
module qbpe_port
   import qbpe_pkg::*;
(
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   input  wire logic                    load,
   input  wire logic [QBPE_PORT_W-1:0]  wdata,
   input  wire logic                    scl_fall,
   output logic      [QBPE_PORT_W-1:0]  latch_q,
   output logic      [QBPE_PORT_W-1:0]  port_pins_o,
   output logic      [QBPE_PORT_W-1:0]  port_pins_oe_n,
   output logic      [QBPE_PORT_W-1:0]  port_pins_pu
);

   logic [QBPE_PORT_W-1:0]  strong_q;

   // Latch low drives hard low; latch high is weak unless just written
   assign port_pins_o    = latch_q;
   assign port_pins_oe_n = latch_q & ~strong_q;
   assign port_pins_pu   = latch_q;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         latch_q  <= QBPE_LATCH_RST;
         strong_q <= '0;
      end else if (load) begin
         latch_q  <= wdata;
         strong_q <= wdata;
      end else if (scl_fall) begin
         strong_q <= '0;
      end
   end

endmodule

// ==== hw/qbpe_expander.sv ====
/*
 * Serial target engine of the quasi-bidirectional port expander: bus decode,
 * address match, one-byte read and write, and pin-change alert.
 * Assumes scl, sda, address selects and port pins are asynchronous pins;
 * open-drain lines are resolved outside from the _oe_n enables.
 */
module qbpe_expander
   import qbpe_pkg::*;
(
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   input  wire logic                    scl_i,
   input  wire logic                    sda_i,
   output logic                         sda_o,
   output logic                         sda_oe_n,
   input  wire logic                    addr_sel_0,
   input  wire logic                    addr_sel_1,
   input  wire logic                    addr_sel_2,
   input  wire logic [QBPE_PORT_W-1:0]  port_pins_i,
   output logic      [QBPE_PORT_W-1:0]  port_pins_o,
   output logic      [QBPE_PORT_W-1:0]  port_pins_oe_n,
   output logic      [QBPE_PORT_W-1:0]  port_pins_pu,
   output logic                         alert_o,
   output logic                         alert_oe_n
);

   // Synchronised view of every pin
   logic [QBPE_SYNC_W-1:0]  sync_q;
   logic                    scl_s;
   logic                    sda_s;
   logic [2:0]              sel_s;
   logic [QBPE_PORT_W-1:0]  pins_s;
   logic                    scl_prev_q;
   logic                    sda_prev_q;
   qbpe_bus_ev_s            ev;

   // Serial engine
   qbpe_state_e             st_q;
   qbpe_state_e             st_d;
   logic [3:0]              cnt_q;
   logic [3:0]              cnt_d;
   logic [7:0]              sh_q;
   logic [7:0]              sh_d;
   logic                    low_q;
   logic                    low_d;
   logic                    load;
   logic                    clr;
   logic                    addr_hit;
   logic                    byte_full;

   // Port and alert
   logic [QBPE_PORT_W-1:0]  latch_q;
   logic [QBPE_PORT_W-1:0]  ref_q;
   logic [QBPE_PORT_W-1:0]  ref_d;
   logic                    alert_q;
   logic                    alert_d;

   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
      shift_in = {v[6:0], b};
   endfunction

   qbpe_sync #(
      .W   (QBPE_SYNC_W),
      .RST ({QBPE_SYNC_W{1'b1}})
   ) u_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .d       ({scl_i, sda_i, addr_sel_2, addr_sel_1, addr_sel_0, port_pins_i}),
      .q       (sync_q)
   );

   assign scl_s  = sync_q[QBPE_SYNC_SCL];
   assign sda_s  = sync_q[QBPE_SYNC_SDA];
   assign sel_s  = sync_q[QBPE_SYNC_A2:QBPE_SYNC_A0];
   assign pins_s = sync_q[QBPE_PORT_W-1:0];

   // Bus events from synced samples only
   assign ev.scl_rise = scl_s & ~scl_prev_q;
   assign ev.scl_fall = ~scl_s & scl_prev_q;
   assign ev.start    = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign ev.stop     = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
   assign ev.sda      = sda_s;

   // General call 00 never equals the fixed 0111 prefix
   assign addr_hit  = (sh_q[7:1] == {QBPE_ADDR_FIXED, sel_s});
   assign byte_full = (cnt_q == QBPE_BITS_BYTE);

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      sh_d  = sh_q;
      low_d = low_q;
      load  = 1'b0;
      clr   = 1'b0;
      if (ev.stop) begin
         st_d  = QBPE_IDLE;
         low_d = 1'b0;
      end else if (ev.start) begin
         st_d  = QBPE_ADDR;
         cnt_d = '0;
         low_d = 1'b0;
      end else begin
         case (st_q)
            QBPE_ADDR: begin
               if (ev.scl_rise && !byte_full) begin
                  sh_d  = shift_in(sh_q, ev.sda);
                  cnt_d = cnt_q + 4'h1;
               end else if (ev.scl_fall && byte_full) begin
                  if (addr_hit) begin
                     st_d  = QBPE_ADDR_ACK;
                     low_d = 1'b1;
                  end else begin
                     st_d  = QBPE_IGNORE;
                  end
               end
            end
            QBPE_ADDR_ACK: begin
               if (ev.scl_fall) begin
                  cnt_d = '0;
                  if (sh_q[0]) begin
                     st_d  = QBPE_RD_DATA;
                     sh_d  = pins_s;
                     low_d = ~pins_s[7];
                  end else begin
                     st_d  = QBPE_WR_DATA;
                     low_d = 1'b0;
                  end
               end
            end
            QBPE_RD_DATA: begin
               if (ev.scl_fall) begin
                  if (cnt_q == QBPE_LAST_BIT) begin
                     st_d  = QBPE_RD_ACK;
                     low_d = 1'b0;
                  end else begin
                     sh_d  = shift_in(sh_q, 1'b0);
                     low_d = ~sh_q[6];
                     cnt_d = cnt_q + 4'h1;
                  end
               end
            end
            QBPE_RD_ACK: begin
               if (ev.scl_rise) begin
                  clr = 1'b1;
               end
               if (ev.scl_fall) begin
                  st_d = QBPE_IGNORE;
               end
            end
            QBPE_WR_DATA: begin
               if (ev.scl_rise && !byte_full) begin
                  sh_d  = shift_in(sh_q, ev.sda);
                  cnt_d = cnt_q + 4'h1;
               end else if (ev.scl_fall && byte_full) begin
                  st_d  = QBPE_WR_ACK;
                  low_d = 1'b1;
                  clr   = 1'b1;
               end
            end
            QBPE_WR_ACK: begin
               if (ev.scl_rise) begin
                  load = 1'b1;
               end
               if (ev.scl_fall) begin
                  st_d  = QBPE_IGNORE;
                  low_d = 1'b0;
               end
            end
            QBPE_IDLE,
            QBPE_IGNORE: begin
               low_d = 1'b0;
            end
            default: begin
               st_d  = QBPE_IDLE;
               low_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q       <= QBPE_IDLE;
         cnt_q      <= '0;
         sh_q       <= '0;
         low_q      <= 1'b0;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         st_q       <= st_d;
         cnt_q      <= cnt_d;
         sh_q       <= sh_d;
         low_q      <= low_d;
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   assign sda_o    = 1'b0;
   assign sda_oe_n = ~low_q;

   qbpe_port u_port (
      .ref_clk        (ref_clk),
      .rst            (rst),
      .load           (load),
      .wdata          (sh_q),
      .scl_fall       (ev.scl_fall),
      .latch_q        (latch_q),
      .port_pins_o    (port_pins_o),
      .port_pins_oe_n (port_pins_oe_n),
      .port_pins_pu   (port_pins_pu)
   );

   // Reference is the pin picture at the last access; written ones are
   // assumed high so that releasing a pin does not raise a false alert
   assign ref_d = clr  ? pins_s :
                  load ? (ref_q | sh_q) :
                  ref_q;

   // Only pins latched high act as inputs; returning pins drop the alert
   assign alert_d = |((pins_s ^ ref_q) & latch_q) & ~clr;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ref_q   <= QBPE_REF_RST;
         alert_q <= 1'b0;
      end else begin
         ref_q   <= ref_d;
         alert_q <= alert_d;
      end
   end

   assign alert_o    = 1'b0;
   assign alert_oe_n = ~alert_q;

endmodule

// ==== bench/qbpe_monitor.sv ====
/*
 * Pin-level checker of the port expander.
 * Assumes the serial clock phases last far longer than eight ref_clk cycles.
 */
module qbpe_monitor
   import qbpe_pkg::*;
(
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   input  wire logic                    scl_i,
   input  wire logic                    sda_o,
   input  wire logic                    sda_oe_n,
   input  wire logic [QBPE_PORT_W-1:0]  port_pins_i,
   input  wire logic [QBPE_PORT_W-1:0]  port_pins_o,
   input  wire logic [QBPE_PORT_W-1:0]  port_pins_oe_n,
   input  wire logic [QBPE_PORT_W-1:0]  port_pins_pu,
   input  wire logic                    alert_o,
   input  wire logic                    alert_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   sda_value_a: assert property (sda_o == 1'b0)
      else $error("sda drive value not low");
   alert_value_a: assert property (alert_o == 1'b0)
      else $error("alert drive value not low");
   pullup_latch_a: assert property (port_pins_pu == port_pins_o)
      else $error("weak pull-up differs from latch");
   strong_low_a: assert property ((~port_pins_o & port_pins_oe_n) == 8'h00)
      else $error("latched zero not driven low");
   strong_off_a: assert property ($fell(scl_i) |-> ##8 ((port_pins_oe_n | ~port_pins_o) == 8'hFF))
      else $error("strong pull-up kept past clock fall");
   ack_in_low_a: assert property ($changed(sda_oe_n) |-> !scl_i)
      else $error("sda drive changed while clock high");
   latch_in_high_a: assert property ($changed(port_pins_o) |-> scl_i)
      else $error("port latch changed outside clock high");
   alert_cause_a: assert property ($fell(alert_oe_n) |-> port_pins_i != $past(port_pins_i, 8))
      else $error("alert raised without pin change");
endmodule

bind qbpe_expander qbpe_monitor MON (.ref_clk, .rst, .scl_i, .sda_o, .sda_oe_n, .port_pins_i, .port_pins_o,
   .port_pins_oe_n, .port_pins_pu, .alert_o, .alert_oe_n);

// ==== bench/qbpe_ctrl_model.sv ====
/*
 * Behavioural serial bus controller driving clock and pulling data low.
 * Assumes the data wire is resolved outside with a pull-up.
 */
module qbpe_ctrl_model
   import qbpe_pkg::*;
(
   input  wire logic  ref_clk,
   input  wire logic  sda,
   output logic       scl,
   output logic       sda_low
);
   timeunit 1ns;
   timeprecision 100ps;
   // Slower than the link rate: the design needs ten clocks per phase
   localparam int H = 30;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic half();
      repeat (H) @(posedge ref_clk);
   endtask

   task automatic start();
      sda_low <= 1'b0;
      half();
      scl <= 1'b1;
      half();
      sda_low <= 1'b1;
      half();
      scl <= 1'b0;
      half();
   endtask

   task automatic stop();
      sda_low <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      sda_low <= 1'b0;
      half();
   endtask

   task automatic clk_bit(input logic b, output logic r);
      sda_low <= !b;
      half();
      scl <= 1'b1;
      half();
      r = sda;
      scl <= 1'b0;
      half();
   endtask

   task automatic xfer(input logic [7:0] w, input logic ack_bit, output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--) clk_bit(w[i], r[i]);
      clk_bit(ack_bit, ack);
   endtask
endmodule

// ==== bench/tb_i2c_quasi_bidir_port_expander.sv ====
/*
 * Self-checking bench of the port expander with a bus controller model.
 * Assumes the design, checker and controller model are compiled first.
 */
module tb_i2c_quasi_bidir_port_expander
   import qbpe_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic                    ref_clk;
   logic                    rst;
   logic [2:0]              sel;
   logic [QBPE_PORT_W-1:0]  ext_low;
   wire                     scl, sda_low, sda, sda_oe_n, alert_oe_n;
   wire  [QBPE_PORT_W-1:0]  pins, pins_o, pins_oe_n, pins_pu;
   int                      failures = 0;
   int                      checks = 0;

   assign sda = !sda_low & sda_oe_n;
   assign pins = (~pins_oe_n & pins_o) | (pins_oe_n & pins_pu & ~ext_low);

   qbpe_ctrl_model CTRL (.ref_clk, .sda, .scl, .sda_low);
   qbpe_expander DUT (.ref_clk, .rst, .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_n, .addr_sel_0(sel[0]),
      .addr_sel_1(sel[1]), .addr_sel_2(sel[2]), .port_pins_i(pins), .port_pins_o(pins_o),
      .port_pins_oe_n(pins_oe_n), .port_pins_pu(pins_pu), .alert_o(), .alert_oe_n);

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic check(input logic ok, input string msg);
      checks++;
      if (!ok) begin
         failures++;
         $display("MISMATCH at %0t ns: %s", $time, msg);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   function automatic logic [7:0] adr(input logic [2:0] s, input logic rd);
      return {QBPE_ADDR_FIXED, s, rd};
   endfunction

   task automatic xact(input logic [7:0] a, input logic [7:0] d, input int n, output logic a0, output logic a1,
                       output logic [7:0] r);
      logic        a2;
      logic [7:0]  r2;
      CTRL.start();
      CTRL.xfer(a, 1'b1, r2, a0);
      CTRL.xfer(d, 1'b1, r, a1);
      if (n > 1) CTRL.xfer(~d, 1'b1, r2, a2);
      CTRL.stop();
   endtask

   task automatic t_write();
      logic        a0, a1;
      logic [7:0]  r, v;
      for (int i = 0; i < 8; i++) begin
         v = 8'(8'h5A ^ (i * 8'h13));
         sel <= 3'(i);
         settle(8);
         xact(adr(3'(i), 1'b0), v, (i == 7) ? 2 : 1, a0, a1, r);
         check(a0 === 1'b0 && a1 === 1'b0, "write not acknowledged");
         check(pins_o === v && pins === v, "port value after write");
         check(alert_oe_n === 1'b1, "alert raised by own write");
      end
      $display("test write done");
   endtask

   task automatic t_alert();
      logic        a0, a1;
      logic [7:0]  r;
      logic [7:0]  bad [3] = '{8'h00, 8'h70, 8'hF0};
      xact(adr(sel, 1'b0), 8'hFF, 1, a0, a1, r);
      ext_low <= 8'h81;
      settle(20);
      check(alert_oe_n === 1'b0, "alert not raised");
      ext_low <= 8'h00;
      settle(20);
      check(alert_oe_n === 1'b1, "alert not cleared on return");
      ext_low <= 8'h81;
      settle(20);
      foreach (bad[k]) begin
         xact(bad[k], 8'h00, 1, a0, a1, r);
         check(a0 === 1'b1 && pins_o === 8'hFF && alert_oe_n === 1'b0, "foreign transfer answered");
      end
      xact(adr(sel, 1'b1), 8'hFF, 1, a0, a1, r);
      check(a0 === 1'b0 && r === 8'h7E, "read data");
      check(alert_oe_n === 1'b1, "alert not cleared by read");
      ext_low <= 8'h00;
      $display("test alert done");
   endtask

   task automatic t_partial();
      logic        a0, b;
      logic [7:0]  r;
      CTRL.start();
      CTRL.xfer(adr(sel, 1'b0), 1'b1, r, a0);
      for (int i = 0; i < 4; i++) CTRL.clk_bit(1'b0, b);
      CTRL.stop();
      check(a0 === 1'b0 && pins_o === 8'hFF, "partial byte reached port");
      $display("test partial done");
   endtask

   task automatic print_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      sel = 3'b000;
      ext_low = 8'h00;
      settle(20);
      rst <= 1'b0;
      settle(5);
      check(pins_o === 8'hFF && pins_oe_n === 8'hFF && pins_pu === 8'hFF, "port after reset");
      check(sda_oe_n === 1'b1 && alert_oe_n === 1'b1, "lines after reset");
      t_write();
      t_alert();
      t_partial();
      print_verdict();
   end

   // Normal run is near 26000 cycles
   initial begin
      settle(60000);
      failures++;
      $display("MISMATCH at %0t ns: watchdog expired", $time);
      print_verdict();
   end
endmodule
